// ==== rtl/enable_latches_defs.svh ====
// field positions, reset values and timing constants for the enable latch block
// assumes inclusion by bare name from rtl files
`ifndef ENABLE_LATCHES_DEFS_SVH
`define ENABLE_LATCHES_DEFS_SVH
`define BUS_W 2
`define BUS_OUT_RESET 2'h0
`define BUS_TEST_RESET 2'h3
`define RX_PWR_RESET 1'h0
`define RX_PWR_BIT 0
`define CLK_PERIOD_PS 5000
`define EV_LINK_FAULT 0
`define EV_RX_PWR 1
`define EV_TEST 2
`define EV_W 3
`define ADDR_STATUS 4'h0
`define ADDR_MASK 4'h4
`define ADDR_STATE 4'h8
`define ADDR_FAULTS 4'hc
`endif

// ==== rtl/enable_latches_pkg.sv ====
// types shared by the enable latch block
// no surroundings assumed
package enable_latches_pkg;
  typedef enum logic [1:0] {
    LATCH_HOLD = 2'b00,
    LATCH_OPEN = 2'b01,
    LATCH_CLOSE = 2'b10
  } latch_phase_t;
endpackage : enable_latches_pkg

// ==== rtl/pin_sync.sv ====
// two flip-flop synchroniser for a group of asynchronous pins
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      meta_reg <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule : pin_sync

// ==== rtl/enable_latches.sv ====
// static configuration latches, link fault output, small register port
// assumes pins are asynchronous to i_core_clk; register port is on i_core_clk
//
// Summary of operation
// - output-enable latch enable high passes both bus bits to the output drivers.
// - a high driver enable bit enables the driver, low powers it down.
// - output-enable latch enable falling holds the last bus values.
// - reset clears the output latch, disabling both drivers.
// - self-test latch enable high passes bus bits to the self-test enables.
// - low self-test bit runs self-test; high bit selects normal data.
// - self-test latch enable falling captures the last bus values.
// - reset while self-test latch closed disables self-test on both channels.
// - receive power latch enable high passes bus bit 0 to receive power.
// - high receive power keeps PLL and analog active, low saves power.
// - receive power latch enable falling captures the last bus bit 0.
// - reset while receive power latch closed disables the receive channel.
// - active-low link fault is the OR of frequency, amplitude, density faults.
// - a disabled receive channel is the fourth link fault condition.
// - reset is active when sampled low on a rising clock edge.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "enable_latches_defs.svh"
module enable_latches
  import enable_latches_pkg::*;
#(
  parameter int BUS_W = `BUS_W
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_out_en_latch_enable,
  input wire logic i_selftest_latch_enable,
  input wire logic i_rx_power_latch_enable,
  input wire logic [BUS_W-1:0] i_shared_enable_bus,
  input wire logic i_freq_out_of_range,
  input wire logic i_amplitude_low,
  input wire logic i_density_low,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic [BUS_W-1:0] o_serial_out_driver_en,
  output logic [BUS_W-1:0] o_selftest_en_n,
  output logic o_rx_power_en,
  output logic o_link_fault_n,
  output logic o_irq
);
  // synchronised pins; the second stage is the only one read
  logic [BUS_W-1:0] bus_s;
  logic oe_le_s;
  logic st_le_s;
  logic rx_le_s;
  logic [2:0] fault_s;
  logic [2:0] le_s;

  pin_sync #(.W(BUS_W), .RESET_VAL('0)) u_bus_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async(i_shared_enable_bus),
    .o_sync(bus_s)
  );

  pin_sync #(.W(3), .RESET_VAL(3'h0)) u_le_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async({i_rx_power_latch_enable, i_selftest_latch_enable, i_out_en_latch_enable}),
    .o_sync(le_s)
  );

  pin_sync #(.W(3), .RESET_VAL(3'h0)) u_fault_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async({i_density_low, i_amplitude_low, i_freq_out_of_range}),
    .o_sync(fault_s)
  );

  assign oe_le_s = le_s[0];
  assign st_le_s = le_s[1];
  assign rx_le_s = le_s[2];

  // latch contents
  logic [BUS_W-1:0] out_en_reg;
  logic [BUS_W-1:0] out_en_next;
  logic [BUS_W-1:0] test_en_reg;
  logic [BUS_W-1:0] test_en_next;
  logic rx_pwr_reg;
  logic rx_pwr_next;
  logic oe_le_d_reg;
  logic st_le_d_reg;
  logic rx_le_d_reg;
  latch_phase_t oe_phase;

  // transparent while the enable is high, hold otherwise
  assign out_en_next = oe_le_s ? bus_s : out_en_reg;
  assign test_en_next = st_le_s ? bus_s : test_en_reg;
  assign rx_pwr_next = rx_le_s ? bus_s[`RX_PWR_BIT] : rx_pwr_reg;

  // phase of the output latch, visible in the state register
  always_comb begin
    case ({oe_le_d_reg, oe_le_s})
      2'b01: oe_phase = LATCH_OPEN;
      2'b10: oe_phase = LATCH_CLOSE;
      2'b11: oe_phase = LATCH_OPEN;
      default: oe_phase = LATCH_HOLD;
    endcase
  end

  // reset sampled on the clock; output and receive power latches are cleared, the self-test latch is set to all ones
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      out_en_reg <= `BUS_OUT_RESET;
      test_en_reg <= `BUS_TEST_RESET;
      rx_pwr_reg <= `RX_PWR_RESET;
      oe_le_d_reg <= 1'b0;
      st_le_d_reg <= 1'b0;
      rx_le_d_reg <= 1'b0;
    end else begin
      out_en_reg <= out_en_next;
      test_en_reg <= test_en_next;
      rx_pwr_reg <= rx_pwr_next;
      oe_le_d_reg <= oe_le_s;
      st_le_d_reg <= st_le_s;
      rx_le_d_reg <= rx_le_s;
    end
  end

  // drive outputs directly from the latch flops
  assign o_serial_out_driver_en = out_en_reg;
  assign o_selftest_en_n = test_en_reg;
  assign o_rx_power_en = rx_pwr_reg;

  // link fault, registered and active low
  logic fault_any;
  logic link_fault_n_reg;
  assign fault_any = (|fault_s) | ~rx_pwr_reg;
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      link_fault_n_reg <= 1'b0;
    end else begin
      link_fault_n_reg <= ~fault_any;
    end
  end
  assign o_link_fault_n = link_fault_n_reg;

  // events: link fault rising, receive power change, self-test latch closing
  logic fault_d_reg;
  logic rx_pwr_d_reg;
  logic [`EV_W-1:0] ev;
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      fault_d_reg <= 1'b1;                                        // receiver is off, fault present
      rx_pwr_d_reg <= `RX_PWR_RESET;
    end else begin
      fault_d_reg <= fault_any;
      rx_pwr_d_reg <= rx_pwr_reg;
    end
  end
  assign ev[`EV_LINK_FAULT] = fault_any & ~fault_d_reg;
  assign ev[`EV_RX_PWR] = rx_pwr_reg ^ rx_pwr_d_reg;
  assign ev[`EV_TEST] = st_le_d_reg & ~st_le_s;

  // register port
  logic [`EV_W-1:0] status_reg;
  logic [`EV_W-1:0] status_next;
  logic [`EV_W-1:0] mask_reg;
  logic [`EV_W-1:0] mask_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic irq_reg;
  wire wr_status = i_wr && (i_addr == `ADDR_STATUS);
  wire wr_mask = i_wr && (i_addr == `ADDR_MASK);
  wire [`EV_W-1:0] clr = wr_status ? i_wdata[`EV_W-1:0] : '0;

  // set wins over write-one-to-clear in the same cycle
  assign status_next = (status_reg & ~clr) | ev;
  assign mask_next = wr_mask ? i_wdata[`EV_W-1:0] : mask_reg;

  wire [31:0] state_word = {22'h0, oe_phase, rx_le_s, st_le_s, oe_le_s,
                            rx_pwr_reg, test_en_reg, out_en_reg};
  wire [31:0] fault_word = {27'h0, ~link_fault_n_reg, ~rx_pwr_reg, fault_s};

  always_comb begin
    rdata_next = 32'h0;
    if (i_rd) begin
      case (i_addr)
        `ADDR_STATUS: rdata_next = {29'h0, status_reg};
        `ADDR_MASK: rdata_next = {29'h0, mask_reg};
        `ADDR_STATE: rdata_next = state_word;
        `ADDR_FAULTS: rdata_next = fault_word;
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      status_reg <= '0;
      mask_reg <= '0;
      rdata_reg <= 32'h0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      irq_reg <= |(status_next & mask_next);
    end
  end
  assign o_rdata = rdata_reg;
  assign o_irq = irq_reg;

  // assertions
  sequence s_oe_open;
    oe_le_s;
  endsequence

  sequence s_close(logic le, logic le_d);
    le_d && !le;
  endsequence

  sequence s_read(logic [3:0] a);
    i_rd && (i_addr == a);
  endsequence

  oe_pass_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_oe_open |=> o_serial_out_driver_en == $past(bus_s))
    else $error("output latch not transparent");

  oe_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !oe_le_s |=> $stable(o_serial_out_driver_en))
    else $error("output latch changed while closed");

  oe_reset_a: assert property (@(posedge i_core_clk)
    !i_nrst |=> o_serial_out_driver_en == `BUS_OUT_RESET)
    else $error("output latch not cleared by reset");

  st_pass_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    st_le_s |=> o_selftest_en_n == $past(bus_s))
    else $error("self-test latch not transparent");

  st_capture_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_close(st_le_s, st_le_d_reg) |-> o_selftest_en_n == $past(bus_s) ##1 $stable(o_selftest_en_n))
    else $error("self-test latch lost last value");

  st_reset_a: assert property (@(posedge i_core_clk)
    !i_nrst |=> o_selftest_en_n == `BUS_TEST_RESET)
    else $error("self-test not disabled by reset");

  rx_pass_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    rx_le_s |=> o_rx_power_en == $past(bus_s[`RX_PWR_BIT]))
    else $error("receive power latch not transparent");

  rx_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !rx_le_s |=> $stable(o_rx_power_en))
    else $error("receive power changed while closed");

  rx_reset_a: assert property (@(posedge i_core_clk)
    !i_nrst |=> !o_rx_power_en)
    else $error("receive channel not disabled by reset");

  fault_or_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (|fault_s) |=> !o_link_fault_n)
    else $error("link fault missed a receive fault");

  fault_rx_off_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !o_rx_power_en |=> !o_link_fault_n)
    else $error("link fault missed disabled receiver");

  fault_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (!(|fault_s) && rx_pwr_reg) [*2] |-> o_link_fault_n)
    else $error("link fault with no cause");

  oe_capture_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_close(oe_le_s, oe_le_d_reg) |-> o_serial_out_driver_en == $past(bus_s) ##1
      $stable(o_serial_out_driver_en))
    else $error("output latch lost last value");

  st_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !st_le_s |=> $stable(o_selftest_en_n))
    else $error("self-test latch changed while closed");

  rx_capture_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_close(rx_le_s, rx_le_d_reg) |-> o_rx_power_en == $past(bus_s[`RX_PWR_BIT]) ##1
      $stable(o_rx_power_en))
    else $error("receive power latch lost last value");

  fault_event_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $fell(o_link_fault_n) |-> status_reg[`EV_LINK_FAULT])
    else $error("link fault event not recorded");

  rx_event_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $changed(o_rx_power_en) |=> status_reg[`EV_RX_PWR])
    else $error("receive power event not recorded");

  test_event_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_close(st_le_s, st_le_d_reg) |=> status_reg[`EV_TEST])
    else $error("self-test close event not recorded");

  status_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    wr_status && i_wdata[`EV_LINK_FAULT] && !ev[`EV_LINK_FAULT] |=>
      !status_reg[`EV_LINK_FAULT])
    else $error("status bit not cleared by write");

  status_sticky_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    status_reg[`EV_LINK_FAULT] && !clr[`EV_LINK_FAULT] |=> status_reg[`EV_LINK_FAULT])
    else $error("status bit lost without a clear");

  mask_write_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    wr_mask |=> mask_reg == $past(i_wdata[`EV_W-1:0]))
    else $error("mask write not taken");

  mask_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !wr_mask |=> $stable(mask_reg))
    else $error("mask changed without a write");

  irq_level_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_irq == |(status_reg & mask_reg))
    else $error("interrupt does not follow masked status");

  rdata_idle_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside a read");

  state_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_read(`ADDR_STATE) |=> o_rdata[BUS_W-1:0] == $past(o_serial_out_driver_en))
    else $error("state read lost driver enables");

  fault_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_read(`ADDR_FAULTS) |=> o_rdata == {27'h0, !$past(o_link_fault_n),
      !$past(o_rx_power_en), $past(fault_s)})
    else $error("fault read does not match fault state");

  status_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_read(`ADDR_STATUS) |=> o_rdata[`EV_W-1:0] == $past(status_reg))
    else $error("status read does not match status");

  fault_release_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $rose(o_link_fault_n) |-> $past(o_rx_power_en))
    else $error("link fault released with receiver off");

  irq_reset_a: assert property (@(posedge i_core_clk)
    !i_nrst |=> !o_irq)
    else $error("interrupt not cleared by reset");

  rdata_reset_a: assert property (@(posedge i_core_clk)
    !i_nrst |=> o_rdata == 32'h0)
    else $error("read data not cleared by reset");

  fault_reset_a: assert property (@(posedge i_core_clk)
    !i_nrst |=> !o_link_fault_n)
    else $error("link fault not shown during reset");

  status_reset_a: assert property (@(posedge i_core_clk)
    !i_nrst |=> status_reg == '0)
    else $error("status not cleared by reset");
endmodule : enable_latches

// ==== testbench/cfg_host.sv ====
// host model: opens one latch, moves the shared bus, closes the latch
// assumes tb pulses i_go for one cycle and waits for o_busy to fall
`timescale 1ns/1ps
module cfg_host (
  input wire logic i_core_clk,
  input wire logic i_go,
  input wire logic [1:0] i_sel,
  input wire logic [1:0] i_val,
  output logic [2:0] o_le,
  output logic [1:0] o_bus,
  output logic o_busy
);
  initial begin
    o_le = 3'h0;
    o_bus = 2'h3;
    o_busy = 1'b0;
    forever begin
      @(posedge i_core_clk);
      if (i_go) begin
        o_busy <= 1'b1;
        o_bus <= ~i_val;
        o_le[i_sel] <= 1'b1;
        repeat (5) @(posedge i_core_clk);
        o_bus <= i_val;
        repeat (5) @(posedge i_core_clk);
        o_le <= 3'h0;
        repeat (4) @(posedge i_core_clk);
        // bus held past the enable fall, then moved away
        o_bus <= ~i_val;
        o_busy <= 1'b0;
      end
    end
  end
endmodule : cfg_host

// ==== testbench/tb.sv ====
// self-checking bench for the enable latch block
// assumes cfg_host drives the latch pins; bench drives faults and registers
`timescale 1ns/1ps
module tb;
  logic clk, nrst, go, wr, rd, busy, lfn, irq, rxp;
  logic [1:0] sel, val, bus, drv, stn;
  logic [2:0] le, flt;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, d;
  int miscompares = 0;
  int samples_checked = 0;
  enable_latches dut (.i_core_clk(clk), .i_nrst(nrst), .i_out_en_latch_enable(le[0]),
    .i_selftest_latch_enable(le[1]), .i_rx_power_latch_enable(le[2]),
    .i_shared_enable_bus(bus), .i_freq_out_of_range(flt[0]), .i_amplitude_low(flt[1]),
    .i_density_low(flt[2]), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_serial_out_driver_en(drv), .o_selftest_en_n(stn),
    .o_rx_power_en(rxp), .o_link_fault_n(lfn), .o_irq(irq));
  cfg_host host (.i_core_clk(clk), .i_go(go), .i_sel(sel), .i_val(val), .o_le(le),
    .o_bus(bus), .o_busy(busy));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  task automatic load(input logic [1:0] s, input logic [1:0] v);
    @(posedge clk);
    go <= 1'b1; sel <= s; val <= v;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 30 && busy !== 1'b0; i++) @(posedge clk);
    repeat (6) @(posedge clk);
    #1;
  endtask : load
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg
  task automatic t_reset_vals;
    chk("drv", drv, 2'h0);
    chk("stn", stn, 2'h3);
    chk("rxp", rxp, 1'h0);
    chk("lfn", lfn, 1'h0);
    chk("irq", irq, 1'h0);
    chk("rdata", rdata, 32'h0);
    $display("reset values done");
  endtask : t_reset_vals
  task automatic t_latches;
    load(2'h0, 2'h2);
    chk("drv", drv, 2'h2);
    rreg(4'h8, d);
    chk("state", d[1:0], 2'h2);
    load(2'h1, 2'h1);
    chk("stn", stn, 2'h1);
    chk("drv held", drv, 2'h2);
    load(2'h2, 2'h1);
    chk("rxp", rxp, 1'h1);
    chk("lfn", lfn, 1'h1);
    rreg(4'h0, d);
    chk("events", d[2:0], 3'h6);
    $display("latch loads done");
  endtask : t_latches
  task automatic t_faults;
    wreg(4'h0, 32'h7);
    wreg(4'h4, 32'h1);
    for (int f = 0; f < 3; f++) begin
      @(posedge clk) flt <= 3'h1 << f;
      repeat (8) @(posedge clk);
      #1 chk("lfn fault", lfn, 1'h0);
      chk("irq", irq, 1'h1);
      rreg(4'h0, d);
      chk("status", d[0], 1'h1);
      wreg(4'h0, 32'h1);
      repeat (2) @(posedge clk);
      #1 chk("irq clr", irq, 1'h0);
      @(posedge clk) flt <= 3'h0;
      repeat (8) @(posedge clk);
      #1 chk("lfn ok", lfn, 1'h1);
    end
    wreg(4'h4, 32'h0);
    flt <= 3'h4;
    repeat (8) @(posedge clk);
    #1 chk("irq masked", irq, 1'h0);
    @(posedge clk) flt <= 3'h0;
    rreg(4'h2, d);
    chk("unmapped", d, 32'h0);
    $display("faults done");
  endtask : t_faults
  task automatic t_rx_off;
    load(2'h2, 2'h0);
    chk("rxp off", rxp, 1'h0);
    chk("lfn off", lfn, 1'h0);
    rreg(4'hc, d);
    chk("faults", d, 32'h18);
    $display("receiver off done");
  endtask : t_rx_off
  task automatic t_rst2;
    load(2'h2, 2'h1);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 t_reset_vals();
    $display("second reset done");
  endtask : t_rst2
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    test_done();
  end
  initial begin
    nrst = 1'b0; go = 1'b0; sel = 2'h0; val = 2'h0; flt = 3'h0;
    wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 32'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 t_reset_vals();
    t_latches();
    t_faults();
    t_rx_off();
    t_rst2();
    test_done();
  end
endmodule : tb
